// >>> bench/cim_engine_model.sv
// protocol engine model: paces arbitration bits and plays the wired-and bus
`timescale 1ns/1ps

module cim_engine_model (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // bit stream from the mapper
    input wire logic tx_valid_in,
    input wire logic tx_bit_in,
    output logic tx_ready_out,
    output logic bus_bit_out,
    // test controls: clear capture, stall, force a dominant bit
    input wire logic clr_in,
    input wire logic slow_in,
    input wire logic lose_en_in,
    input wire logic [5:0] lose_at_in,
    // bits seen on the bus and their count
    output logic [31:0] got_out,
    output logic [5:0] n_out
);
    ////////////////////////////////////////////////////////////////////////////
    // wired-and bus: idle recessive, another node may drive one bit dominant
    assign bus_bit_out = !tx_valid_in ? 1'b1 :
        ((lose_en_in && n_out == lose_at_in) ? 1'b0 : tx_bit_in);

    ////////////////////////////////////////////////////////////////////////////
    // ready pacing, stalling every other cycle in slow mode; bus bits captured
    always_ff @(posedge core_clk_in) begin
        if (reset_in || clr_in) begin
            tx_ready_out <= 1'b0;
            got_out <= 32'h0000_0000;
            n_out <= 6'h00;
        end else begin
            tx_ready_out <= slow_in ? !tx_ready_out : 1'b1;
            // a bit is taken only with valid and ready both high
            if (tx_valid_in && tx_ready_out) begin
                got_out <= {got_out[30:0], bus_bit_out};
                n_out <= n_out + 6'h01;
            end
        end
    end
endmodule

// >>> bench/tb_top.sv
// testbench: register, reception and arbitration checks of the mapper
`timescale 1ns/1ps

module tb_top;
    // design-side signals
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [1:0] reg_addr_in = 2'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic rx_store_in = 1'b0;
    logic rx_ide_in = 1'b0;
    logic [28:0] rx_id_in = 29'h0000_0000;
    logic rx_srr_in = 1'b0;
    logic rx_rtr_in = 1'b0;
    logic tx_start_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic tx_bit_out, tx_valid_out, tx_ready_in, bus_bit_in;
    logic tx_done_out, arb_lost_out, tx_busy_out;
    // partner controls and capture
    logic clr = 1'b0;
    logic slow = 1'b0;
    logic lose_en = 1'b0;
    logic [5:0] lose_at = 6'h00;
    logic [5:0] got_n;
    logic [31:0] got, w, w_exp;
    int n_fail = 0;
    int compares = 0;
    // identifiers used by the scenarios
    localparam logic [28:0] ID_A = 29'h15A3_C6E9;
    localparam logic [28:0] ID_B = 29'h0ACE_1357;
    localparam logic [10:0] ID_S = 11'h5B3;

    // 250 MHz core clock
    always #2 core_clk_in = ~core_clk_in;

    cim_mapper dut (.core_clk_in(core_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .rx_store_in(rx_store_in), .rx_ide_in(rx_ide_in),
        .rx_id_in(rx_id_in), .rx_srr_in(rx_srr_in), .rx_rtr_in(rx_rtr_in),
        .tx_start_in(tx_start_in), .tx_bit_out(tx_bit_out), .tx_valid_out(tx_valid_out),
        .tx_ready_in(tx_ready_in), .bus_bit_in(bus_bit_in), .tx_done_out(tx_done_out),
        .arb_lost_out(arb_lost_out), .tx_busy_out(tx_busy_out));
    cim_engine_model eng (.core_clk_in(core_clk_in), .reset_in(reset_in),
        .tx_valid_in(tx_valid_out), .tx_bit_in(tx_bit_out), .tx_ready_out(tx_ready_in),
        .bus_bit_out(bus_bit_in), .clr_in(clr), .slow_in(slow), .lose_en_in(lose_en),
        .lose_at_in(lose_at), .got_out(got), .n_out(got_n));

    ////////////////////////////////////////////////////////////////////////////
    // expected extended layout of the four bytes, byte 0 in the top bits
    function automatic logic [31:0] pack_ext(input logic [28:0] id, input logic srr,
        input logic ide, input logic rtr);
        return {id[28:18], srr, ide, id[17:0], rtr};
    endfunction

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // register port: one-cycle strobes, read data in the following cycle
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        d = reg_rdata_out;
    endtask

    // all four bytes as one word, byte 0 highest
    task automatic wr_all(input logic [31:0] v);
        for (int i = 0; i < 4; i++) wr(2'(i), v[31 - 8 * i -: 8]);
    endtask

    task automatic rd_all(output logic [31:0] v);
        logic [7:0] b;
        for (int i = 0; i < 4; i++) begin
            rd(2'(i), b);
            v[31 - 8 * i -: 8] = b;
        end
    endtask

    // one reception store pulse from the engine
    task automatic rx(input logic ide, input logic [28:0] id, input logic srr, input logic rtr);
        @(posedge core_clk_in);
        rx_store_in <= 1'b1;
        rx_ide_in <= ide;
        rx_id_in <= id;
        rx_srr_in <= srr;
        rx_rtr_in <= rtr;
        @(posedge core_clk_in);
        rx_store_in <= 1'b0;
    endtask

    // start a send, wait bounded for done or loss, check what the bus saw
    task automatic send(input logic [5:0] at, input logic en, input logic sl,
        input logic lost, input logic [5:0] n, input logic [31:0] bits);
        @(posedge core_clk_in);
        clr <= 1'b1;
        lose_at <= at;
        lose_en <= en;
        slow <= sl;
        tx_start_in <= 1'b1;
        @(posedge core_clk_in);
        clr <= 1'b0;
        tx_start_in <= 1'b0;
        for (int k = 0; k < 300; k++) begin
            @(posedge core_clk_in);
            #1;
            if (tx_done_out === 1'b1 || arb_lost_out === 1'b1) break;
        end
        chk(arb_lost_out, lost);
        chk(tx_done_out, !lost);
        chk(got_n, n);
        chk(got, bits);
        chk(tx_busy_out, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (10) @(posedge core_clk_in);
        reset_in <= 1'b0;
        #1;
        chk(reg_rdata_out, 8'h00);
        // software fills an extended buffer, substitute bit written as one
        w_exp = pack_ext(ID_A, 1'b1, 1'b1, 1'b0);
        wr_all(w_exp);
        rd_all(w);
        chk(w, w_exp);
        // full extended field with a stalling engine, then loss at the third bit
        send(6'h00, 1'b0, 1'b1, 1'b0, cim_pkg::CIM_EXT_BITS, w_exp);
        send(6'h02, 1'b1, 1'b0, 1'b1, 6'h03, 32'h0000_0004);
        // standard buffer, remote frame
        wr(cim_pkg::CIM_OFS_HIGH, ID_S[10:3]);
        wr(cim_pkg::CIM_OFS_FLAGS, {ID_S[2:0], 1'b1, 1'b0, 3'h5});
        send(6'h00, 1'b0, 1'b0, 1'b0, cim_pkg::CIM_STD_BITS, {19'h0, ID_S, 2'h2});
        // extended reception, substitute bit stored as sampled
        w_exp = pack_ext(ID_B, 1'b0, 1'b1, 1'b1);
        rx(1'b1, ID_B, 1'b0, 1'b1);
        rd_all(w);
        chk(w, w_exp);
        // a second reset leaves the bytes alone
        @(posedge core_clk_in);
        reset_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        reset_in <= 1'b0;
        rd_all(w);
        chk(w, w_exp);
        // standard reception touches byte 0 and the top of byte 1 only
        rx(1'b0, {18'h0, ID_S}, 1'b1, 1'b0);
        rd_all(w);
        chk(w[31:19], {ID_S, 2'h0});
        chk(w[18:0], w_exp[18:0]);
        final_report;
    end

    // watchdog against a hung handshake
    initial begin
        #80000;
        n_fail++;
        final_report;
    end
endmodule

// >>> inc/cim_pkg.sv
// constants and types shared by the identifier field mapper
//
// Summary of operation
// R01: extended group holds 32 bits total
// R02: standard group carries 13 meaningful bits
// R03: extended identifier bits outside 14..7 land in bytes 0, 1, 3
// R04: identifier bits 14..7 fill byte 2
// R05: identifier sent most significant bit first
// R06: smallest identifier wins arbitration on the bus
// R07: software writes substitute remote bit as one
// R08: substitute remote bit stored exactly as received
// R09: extension bit stored as received on reception
// R10: extension bit selects standard or extended send
// R11: extended remote request sits at byte 3 bit 0
// R12: received remote request bit recorded for software
// R13: remote request sent with buffered value
// R14: extended frames carry substitute and extension as one; substitute bit is sent as buffered and stored as received
// R15: standard identifier lands in bytes 0 and 1
// R16: identifier bytes are not cleared by reset
package cim_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets on the byte port
    localparam logic [1:0] CIM_OFS_HIGH = 2'h0;  // ident_byte_high
    localparam logic [1:0] CIM_OFS_FLAGS = 2'h1; // ident_byte_flags
    localparam logic [1:0] CIM_OFS_MID = 2'h2;   // ident_byte_mid
    localparam logic [1:0] CIM_OFS_LOW = 2'h3;   // ident_byte_low

    ////////////////////////////////////////////////////////////////////////////
    // field positions inside ident_byte_flags and ident_byte_low
    localparam int CIM_FLG_SRR_BIT = 4;       // substitute remote, extended
    localparam int CIM_FLG_IDE_BIT = 3;       // identifier extension flag
    localparam int CIM_FLG_STD_RTR_BIT = 4;   // remote request, standard
    localparam int CIM_LOW_EXT_RTR_BIT = 0;   // remote request, extended

    ////////////////////////////////////////////////////////////////////////////
    // sizes of the arbitration field in each format
    localparam logic [5:0] CIM_EXT_BITS = 6'h20; // 29 id + srr + ide + rtr
    localparam logic [5:0] CIM_STD_BITS = 6'h0D; // 11 id + rtr + ide
    localparam logic [5:0] CIM_CNT_ONE = 6'h01;  // counter step

    ////////////////////////////////////////////////////////////////////////////
    // reset values of the control fields
    localparam logic [31:0] CIM_SHIFT_RST = 32'h0000_0000;
    localparam logic [5:0] CIM_CNT_RST = 6'h00;
    localparam logic [7:0] CIM_RDATA_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // serializer states, one-hot
    typedef enum logic [1:0] {
        CIM_ST_IDLE = 2'b01, // waiting for a send request
        CIM_ST_SEND = 2'b10  // shifting the arbitration field out
    } cim_state_type;

    // whole state of the mapper
    typedef struct packed {
        cim_state_type st;          // serializer state
        logic [3:0][7:0] ident;     // the four identifier bytes
        logic [31:0] shift;         // bits still to send, msb first
        logic [5:0] cnt;            // bits sent so far
        logic [5:0] len;            // bits in this frame
        logic [7:0] rdata;          // read data, one cycle after strobe
        logic done;                 // pulse: field sent completely
        logic lost;                 // pulse: arbitration lost
    } cim_regs_type;

endpackage

// >>> rtl/cim_mapper.sv
// identifier field mapper: byte registers, reception store, arbitration serializer
`timescale 1ns/1ps

module cim_mapper (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // software register port
    input wire logic [1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // reception store from the protocol engine
    input wire logic rx_store_in,
    input wire logic rx_ide_in,
    input wire logic [28:0] rx_id_in,
    input wire logic rx_srr_in,
    input wire logic rx_rtr_in,
    // transmit request and bit stream to the protocol engine
    input wire logic tx_start_in,
    output logic tx_bit_out,
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    input wire logic bus_bit_in,
    output logic tx_done_out,
    output logic arb_lost_out,
    output logic tx_busy_out
);

    ////////////////////////////////////////////////////////////////////////////
    // state registers
    cim_pkg::cim_regs_type r_ff;   // registered state
    cim_pkg::cim_regs_type nxt_r;  // next state

    logic bit_taken;    // engine accepts the current bit
    logic bit_lost;     // we sent recessive, bus showed dominant
    logic last_bit;     // current bit is the final one of the field

    ////////////////////////////////////////////////////////////////////////////
    // handshake terms
    always_comb begin
        bit_taken = (r_ff.st == cim_pkg::CIM_ST_SEND) && tx_ready_in;
        // a recessive one overwritten by a dominant zero means a smaller id won
        bit_lost = bit_taken && r_ff.shift[31] && !bus_bit_in; // R06
        last_bit = (r_ff.cnt + cim_pkg::CIM_CNT_ONE) == r_ff.len;
    end

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        nxt_r = r_ff;
        nxt_r.done = 1'b0;
        nxt_r.lost = 1'b0;
        nxt_r.rdata = cim_pkg::CIM_RDATA_RST;

        // read data for the strobe of this cycle, shown in the next one
        if (reg_rd_in) begin
            nxt_r.rdata = r_ff.ident[3 - reg_addr_in];
        end

        // software write to one byte
        if (reg_wr_in) begin
            nxt_r.ident[3 - reg_addr_in] = reg_wdata_in;
        end

        // a reception overrides a same-cycle software write on the bits it stores
        if (rx_store_in) begin
            // extension flag lives in ident_byte_flags, written in both formats
            nxt_r.ident[2][cim_pkg::CIM_FLG_IDE_BIT] = rx_ide_in; // R09
            if (rx_ide_in) begin
                // extended layout
                nxt_r.ident[3] = rx_id_in[28:21]; // R03
                nxt_r.ident[2][7:5] = rx_id_in[20:18]; // R03
                nxt_r.ident[2][cim_pkg::CIM_FLG_SRR_BIT] = rx_srr_in; // R08 R14
                nxt_r.ident[2][cim_pkg::CIM_FLG_IDE_BIT] = 1'b1; // R09 R14
                nxt_r.ident[2][2:0] = rx_id_in[17:15]; // R03
                nxt_r.ident[1] = rx_id_in[14:7]; // R04
                nxt_r.ident[0][7:1] = rx_id_in[6:0]; // R03
                nxt_r.ident[0][cim_pkg::CIM_LOW_EXT_RTR_BIT] = rx_rtr_in; // R11 R12
            end else begin
                // standard layout, bytes 2 and 3 are left as they were
                nxt_r.ident[3] = rx_id_in[10:3]; // R15
                nxt_r.ident[2][7:5] = rx_id_in[2:0]; // R15
                nxt_r.ident[2][cim_pkg::CIM_FLG_STD_RTR_BIT] = rx_rtr_in; // R12 R15
                nxt_r.ident[2][cim_pkg::CIM_FLG_IDE_BIT] = 1'b0; // R09 R15
            end
        end

        // serializer
        case (r_ff.st)
            cim_pkg::CIM_ST_IDLE: begin
                if (tx_start_in) begin
                    // byte order equals bus order: ext sends all 32 bits,
                    // standard sends the top 13 (id, rtr, ide)
                    nxt_r.shift = {r_ff.ident[3], r_ff.ident[2], r_ff.ident[1],
                                   r_ff.ident[0]}; // R05 R13
                    nxt_r.cnt = cim_pkg::CIM_CNT_RST;
                    // extension flag picks the field length
                    if (r_ff.ident[2][cim_pkg::CIM_FLG_IDE_BIT]) begin
                        nxt_r.len = cim_pkg::CIM_EXT_BITS; // R01 R10 R14
                    end else begin
                        nxt_r.len = cim_pkg::CIM_STD_BITS; // R02 R10
                    end
                    nxt_r.st = cim_pkg::CIM_ST_SEND;
                end
            end
            cim_pkg::CIM_ST_SEND: begin
                if (bit_lost) begin
                    // back off, the bus belongs to a smaller identifier
                    nxt_r.lost = 1'b1; // R06
                    nxt_r.st = cim_pkg::CIM_ST_IDLE;
                end else if (bit_taken) begin
                    // next bit moves to the top, msb first
                    nxt_r.shift = {r_ff.shift[30:0], 1'b0}; // R05
                    nxt_r.cnt = r_ff.cnt + cim_pkg::CIM_CNT_ONE;
                    if (last_bit) begin
                        nxt_r.done = 1'b1;
                        nxt_r.st = cim_pkg::CIM_ST_IDLE;
                    end
                end
            end
            default: begin
                nxt_r.st = cim_pkg::CIM_ST_IDLE;
            end
        endcase

        // synchronous reset clears control only; identifier bytes keep
        // whatever they hold, as a buffer memory would
        if (reset_in) begin
            nxt_r.st = cim_pkg::CIM_ST_IDLE; // R16
            nxt_r.shift = cim_pkg::CIM_SHIFT_RST;
            nxt_r.cnt = cim_pkg::CIM_CNT_RST;
            nxt_r.len = cim_pkg::CIM_CNT_RST;
            nxt_r.rdata = cim_pkg::CIM_RDATA_RST;
            nxt_r.done = 1'b0;
            nxt_r.lost = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge core_clk_in) begin
        r_ff <= nxt_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata_out = r_ff.rdata;
    assign tx_bit_out = r_ff.shift[31];
    assign tx_valid_out = (r_ff.st == cim_pkg::CIM_ST_SEND);
    assign tx_done_out = r_ff.done;
    assign arb_lost_out = r_ff.lost;
    assign tx_busy_out = (r_ff.st == cim_pkg::CIM_ST_SEND);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);

    // start request seen while idle; reset is left to the default disable
    logic start_ok;
    assign start_ok = (r_ff.st == cim_pkg::CIM_ST_IDLE) && tx_start_in;

    ext_length_a: assert property (start_ok && r_ff.ident[2][3] |=> // R01
        r_ff.len == 6'h20 && tx_valid_out)
        else $error("extended field length not 32");

    std_length_a: assert property (start_ok && !r_ff.ident[2][3] |=> // R02
        r_ff.len == 6'h0D && tx_valid_out)
        else $error("standard field length not 13");

    ext_map_a: assert property (rx_store_in && rx_ide_in |=> // R03
        r_ff.ident[3] == $past(rx_id_in[28:21]) &&
        r_ff.ident[2][7:5] == $past(rx_id_in[20:18]) &&
        r_ff.ident[2][2:0] == $past(rx_id_in[17:15]) &&
        r_ff.ident[0][7:1] == $past(rx_id_in[6:0]))
        else $error("extended identifier misplaced");

    mid_byte_a: assert property (rx_store_in && rx_ide_in |=> // R04
        r_ff.ident[1] == $past(rx_id_in[14:7]))
        else $error("middle identifier byte misplaced");

    first_bit_a: assert property (start_ok |=> // R05
        tx_bit_out == $past(r_ff.ident[3][7]))
        else $error("first bit is not the identifier msb");

    arb_loss_a: assert property (bit_lost |=> // R06
        arb_lost_out && !tx_valid_out ##1 !arb_lost_out)
        else $error("lost arbitration not signalled");

    srr_store_a: assert property (rx_store_in && rx_ide_in |=> // R08
        r_ff.ident[2][4] == $past(rx_srr_in))
        else $error("substitute remote bit not stored");

    ide_store_a: assert property (rx_store_in |=> // R09
        r_ff.ident[2][3] == $past(rx_ide_in))
        else $error("extension bit not stored");

    ext_rtr_a: assert property (rx_store_in && rx_ide_in |=> // R11
        r_ff.ident[0][0] == $past(rx_rtr_in))
        else $error("extended remote bit misplaced");

    std_map_a: assert property (rx_store_in && !rx_ide_in |=> // R15
        r_ff.ident[3] == $past(rx_id_in[10:3]) &&
        r_ff.ident[2][7:4] == {$past(rx_id_in[2:0]), $past(rx_rtr_in)})
        else $error("standard identifier misplaced");

    send_done_a: assert property (bit_taken && !bit_lost && last_bit |=> // R13
        tx_done_out && !tx_valid_out ##1 !tx_done_out)
        else $error("done pulse missing after last bit");

    read_data_a: assert property (reg_rd_in && !reg_wr_in && !rx_store_in |=>
        reg_rdata_out == $past(r_ff.ident[3 - reg_addr_in]))
        else $error("read data wrong");

    ////////////////////////////////////////////////////////////////////////////
    // further checks on storage, serializer and reset behaviour

    // a software write lands in the addressed byte only;
    // a same-cycle reception is excluded because it wins on the bits it stores
    write_land_a: assert property (reg_wr_in && !rx_store_in |=> // R03
        r_ff.ident[3 - $past(reg_addr_in)] == $past(reg_wdata_in))
        else $error("written byte not stored");

    // outside the answer cycle the read port shows zero,
    // so a stale byte is never mistaken for fresh data
    rdata_idle_a: assert property (!reg_rd_in |=> // R01
        reg_rdata_out == 8'h00)
        else $error("read data not zero when idle");

    // a standard reception must not disturb the low flag bits
    // nor the two bytes that only the extended layout uses
    std_keep_a: assert property (rx_store_in && !rx_ide_in && !reg_wr_in |=> // R15
        r_ff.ident[1] == $past(r_ff.ident[1]) &&
        r_ff.ident[0] == $past(r_ff.ident[0]) &&
        r_ff.ident[2][2:0] == $past(r_ff.ident[2][2:0]))
        else $error("standard reception touched extended bytes");

    // the standard remote request sits at flags bit 4,
    // where the extended layout keeps the substitute bit
    std_rtr_a: assert property (rx_store_in && !rx_ide_in |=> // R12
        r_ff.ident[2][4] == $past(rx_rtr_in))
        else $error("standard remote bit not stored");

    // an extended reception always leaves the extension flag set
    ext_flag_a: assert property (rx_store_in && rx_ide_in |=> // R14
        r_ff.ident[2][3] == 1'b1)
        else $error("extension flag not set by extended reception");

    // the whole buffer is loaded at start; the last bit of an
    // extended field is the remote request of byte 3
    ext_load_a: assert property (start_ok && r_ff.ident[2][3] |=> // R11
        r_ff.shift[0] == $past(r_ff.ident[0][0]) &&
        r_ff.shift[31:24] == $past(r_ff.ident[3]))
        else $error("extended field not loaded from buffer");

    // each taken bit moves the next one up, msb first
    shift_step_a: assert property (bit_taken && !bit_lost && !last_bit |=> // R05
        tx_bit_out == $past(r_ff.shift[30]) && tx_valid_out)
        else $error("next bit not presented after a taken bit");

    // while the engine stalls the current bit must stand still
    hold_bit_a: assert property (tx_valid_out && !tx_ready_in |=> // R05
        $stable(tx_bit_out) && tx_valid_out)
        else $error("bit changed while the engine stalled");

    // field length is latched at start and must not move mid-field
    len_hold_a: assert property (tx_valid_out && !bit_lost |=> // R10
        !tx_valid_out || $stable(r_ff.len))
        else $error("field length changed while sending");

    // the bit counter never reaches the length while sending
    cnt_limit_a: assert property (tx_valid_out |-> // R01
        r_ff.cnt < r_ff.len)
        else $error("bit counter ran past the field length");

    // loss is only legal for a recessive bit read back dominant
    lost_cause_a: assert property (arb_lost_out |-> // R06
        $past(r_ff.shift[31]) && !$past(bus_bit_in))
        else $error("arbitration loss without a dominant overwrite");

    // a field ends either completed or lost, never both
    end_excl_a: assert property (!(tx_done_out && arb_lost_out)) // R06
        else $error("done and loss pulsed together");

    // a done pulse means every bit of the latched length went out
    done_count_a: assert property (tx_done_out |-> // R02
        r_ff.cnt == r_ff.len)
        else $error("done pulse before all bits sent");

    // reset clears control but must leave the port quiet;
    // checked with reset active, so the default disable is lifted
    rst_ctrl_a: assert property (disable iff (1'b0) reset_in |=> // R16
        !tx_valid_out && !tx_done_out && !arb_lost_out &&
        reg_rdata_out == 8'h00)
        else $error("control not cleared by reset");

    // a start while sending is ignored: the counter keeps its pace
    start_ignore_a: assert property (tx_valid_out && tx_start_in && !bit_taken |=> // R10
        $stable(r_ff.cnt))
        else $error("start while sending disturbed the field");

endmodule
